// File: testbench/host_port_model.sv
// host serial port model: bit clock, frame sync and the shared or split data wire
// assumes the bench calls one task at a time; the bit clock stands still between calls
`timescale 1ns/100ps
module host_port_model
(
   // link toward the codec
   output logic bitClk,
   output logic frameSync,
   output logic serialInPin,
   output logic slotLayoutSelect,
   // codec answer
   input wire logic serialOutPin,
   input wire logic serialOutPinEn
);
   logic hostBit; // level the host puts on its own line
   logic shared; // one wire for both directions in this frame

   // one wire: the codec owns it while its enable is high
   assign serialInPin = (shared && serialOutPinEn) ? serialOutPin : hostBit;

   // idle levels at time zero
   initial
   begin
      bitClk = 1'b0;
      frameSync = 1'b0;
      hostBit = 1'b0;
      shared = 1'b1;
      slotLayoutSelect = 1'b0;
   end

   // one bit clock period, 15 ns
   task automatic tick();
      #7.5 bitClk = 1'b1;
      #7.5 bitClk = 1'b0;
   endtask : tick

   // edges without a frame, only around reset; released line keeps toggling
   task automatic idle(input int n);
      repeat (n)
      begin
         hostBit = ~hostBit;
         tick();
      end
   endtask : idle

   // one frame: three words sent, three words collected, layout for the following frame
   task automatic run_frame(input logic [47:0] din, input logic nextLayout, output logic [47:0] dout,
      output logic enOk);
      int p;
      int first;
      first = slotLayoutSelect ? 0 : 48;
      shared = !slotLayoutSelect;
      enOk = 1'b1;
      dout = '0;
      for (p = 0; p <= first + 48; p++)
      begin
         frameSync = (p == 0);
         hostBit = (p < 48) ? din[47 - p] : ~hostBit;
         if (p == 2)
            slotLayoutSelect = nextLayout;
         // sample just before edge p what the codec set at edge p-1
         if (p > 0)
            enOk &= (serialOutPinEn === (p > first));
         if (p > first)
            dout[47 - (p - 1 - first)] = serialOutPin;
         tick();
      end
      frameSync = 1'b0;
   endtask : run_frame
endmodule : host_port_model

// File: testbench/tb_codec_tdm_control_slots.sv
// self-checking bench: a reference model of the codec slots is compared at every frame
// assumes host_port_model owns the link; core clock runs at 50 MHz
`timescale 1ns/100ps
`define CHK(what, exp, got) begin tests_run++; if ((exp) !== (got)) begin n_fail++; \
   $display("wrong value %s expected %h seen %h", what, exp, got); end end
module tb_codec_tdm_control_slots import codec_tdm_pkg::*;;
   // core side
   logic clk;
   logic reset;
   logic [15:0] captureLeft, captureRight, dacLeft, dacRight;
   logic [1:0] overLeft, overRight;
   logic dacMute, monoMode, eightBitMode;
   // link
   logic bitClk, frameSync, serialInPin, serialOutPin, serialOutPinEn, slotLayoutSelect;
   // bookkeeping
   int n_fail;
   int tests_run;
   int seed;
   int i;
   logic [7:0] fmts [4];
   localparam logic [7:0] AUX_MUTE = 8'h80; // mute bit of the aux input control words
   // reference model state
   logic [7:0] idx [16];
   logic [15:0] ctrl, playL, playR, pend;
   logic [3:0] ovrStat, ovrIn;
   logic lay, lastClr;

   // 20 ns core clock
   initial clk = 1'b0;
   always #10 clk = ~clk;

   codec_tdm_control_slots dut (.clk(clk), .reset(reset), .bitClk(bitClk), .frameSync(frameSync),
      .serialInPin(serialInPin), .serialOutPin(serialOutPin), .serialOutPinEn(serialOutPinEn),
      .slotLayoutSelect(slotLayoutSelect), .captureLeft(captureLeft), .captureRight(captureRight),
      .overLeft(overLeft), .overRight(overRight), .dacLeft(dacLeft), .dacRight(dacRight),
      .dacMute(dacMute), .monoMode(monoMode), .eightBitMode(eightBitMode));

   host_port_model host (.bitClk(bitClk), .frameSync(frameSync), .serialInPin(serialInPin),
      .slotLayoutSelect(slotLayoutSelect), .serialOutPin(serialOutPin), .serialOutPinEn(serialOutPinEn));

   // control word from its fields, reserved bit zero
   function automatic logic [15:0] cw(input logic clr, input logic mode_change_enable, input logic rq, input logic [3:0] a,
      input logic [7:0] d);
      return {clr, mode_change_enable, rq, 1'b0, a, d};
   endfunction : cw

   // index address that exists
   function automatic logic okAddr(input logic [3:0] a);
      return a != IDX_INVALID_A && a != IDX_INVALID_B && a != IDX_INVALID_C;
   endfunction : okAddr

   // low byte cleared in eight-bit modes
   function automatic logic [15:0] fmt(input logic [15:0] w);
      return (idx[IDX_DATA_FORMAT][6:5] != 2'h0) ? {w[15:8], 8'h00} : w;
   endfunction : fmt

   // readback in control layout, or status when not requested or invalid
   function automatic logic [15:0] answer(input logic [15:0] q, input logic [15:0] st);
      return (q[13] && okAddr(q[11:8])) ? {q[15:13], 1'b0, q[11:8], idx[q[11:8]]} : st;
   endfunction : answer

   // verdict, the only end of the run
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   // one frame through model and design, then compare link words and core outputs
   task automatic do_frame(input logic [15:0] w, input logic nextLay);
      ctrl_word_s c;
      logic [47:0] din, dout;
      logic [15:0] pl, pr, st, reply, eL, eR, cL, cR, mk;
      logic enOk, eMute, eMono, eEight, auto_calibration_bit;
      c = w;
      pl = 16'($random(seed));
      pr = 16'($random(seed));
      din = {w, pl, pr};
      // core outputs take what stood at this frame sync
      eL = playL;
      eR = playR;
      eMute = ctrl[14];
      eMono = idx[IDX_DATA_FORMAT][MONO_BIT];
      eEight = idx[IDX_DATA_FORMAT][6:5] != 2'h0;
      // status refresh at the frame boundary
      mk = (ctrl[15] == lastClr) ? 16'hFFFF : 16'hFFF0;
      lastClr = ctrl[15];
      if (ctrl[15] || ovrIn[1:0] > ovrStat[1:0])
         ovrStat[1:0] = ovrIn[1:0];
      if (ctrl[15] || ovrIn[3:2] > ovrStat[3:2])
         ovrStat[3:2] = ovrIn[3:2];
      st = {4'h0, REVISION_ID, 4'h0, ovrStat};
      reply = answer(pend, st);
      // control word takes effect
      auto_calibration_bit = idx[IDX_IFACE_CONFIG][AUTO_CALIBRATION_BIT_BIT];
      if (c.readbackRequest || okAddr(c.indexAddress))
         ctrl = w;
      if (!c.readbackRequest && okAddr(c.indexAddress) && (c.modeChangeEnable
          || (c.indexAddress != IDX_DATA_FORMAT && c.indexAddress != IDX_MISC_INFO)))
         idx[c.indexAddress] = c.indexData;
      if (!c.modeChangeEnable)
         idx[IDX_IFACE_CONFIG][AUTO_CALIBRATION_BIT_BIT] = auto_calibration_bit;
      if (!lay)
         reply = answer(w, st);
      if (reply !== st)
         mk = 16'hFFFF;
      playL = fmt(pl);
      playR = idx[IDX_DATA_FORMAT][MONO_BIT] ? playL : fmt(pr);
      cL = fmt(captureLeft);
      cR = idx[IDX_DATA_FORMAT][MONO_BIT] ? cL : fmt(captureRight);
      pend = w;
      ovrIn = {overRight, overLeft};
      host.run_frame(din, nextLay, dout, enOk);
      lay = nextLay;
      `CHK("slot enable", 1'b1, enOk)
      `CHK("status or readback", reply & mk, dout[47:32] & mk)
      `CHK("left capture", cL, dout[31:16])
      `CHK("right capture", cR, dout[15:0])
      `CHK("left dac", eL, dacLeft)
      `CHK("right dac", eR, dacRight)
      `CHK("dac mute", eMute, dacMute)
      `CHK("mono", eMono, monoMode)
      `CHK("eight bit", eEight, eightBitMode)
      // fresh capture inputs for the next frame
      @(posedge clk);
      captureLeft <= 16'($random(seed));
      captureRight <= 16'($random(seed));
      overLeft <= 2'($random(seed));
      overRight <= 2'($random(seed));
      // let the new inputs land before the next frame's model reads them
      @(posedge clk);
   endtask : do_frame

   // cuts a hang short
   initial
   begin
      #1000000;
      n_fail++;
      report_and_stop();
   end

   // main sequence
   initial
   begin
      n_fail = 0;
      tests_run = 0;
      seed = 32'hAA125602;
      reset = 1'b1;
      captureLeft = 16'h1234;
      captureRight = 16'hABCD;
      overLeft = 2'h0;
      overRight = 2'h0;
      foreach (idx[k])
         idx[k] = INDEX_RESET;
      ctrl = CTRL_RESET;
      playL = DATA_RESET;
      playR = DATA_RESET;
      pend = 16'h0000;
      ovrStat = 4'h0;
      ovrIn = 4'h0;
      lay = 1'b0;
      lastClr = 1'b1;
      fmts = '{8'h30, 8'h10, 8'h20, 8'h00};
      fork
         host.idle(8);
         repeat (10) @(posedge clk);
      join
      reset <= 1'b0;
      host.idle(6);
      // write then read every index address, invalid ones too
      for (i = 0; i < 16; i++)
      begin
         // aux input words keep their mute bit while mode change is on
         do_frame(cw(1'b1, 1'b1, 1'b0, 4'(i), 8'($random(seed)) | (((i >= 2) && (i <= 5)) ? AUX_MUTE : 8'h00)),
            1'b0);
         do_frame(cw(1'b1, 1'b1, 1'b1, 4'(i), 8'h00), 1'b0);
      end
      // protected registers and the interface config calibration bit refuse writes with mode change off
      for (i = 0; i < 3; i++)
      begin
         do_frame(cw(1'b1, 1'b0, 1'b0, (i == 0) ? IDX_DATA_FORMAT : (i == 1) ? IDX_IFACE_CONFIG : IDX_MISC_INFO,
            8'hFF), 1'b0);
         do_frame(cw(1'b1, 1'b0, 1'b1, (i == 0) ? IDX_DATA_FORMAT : (i == 1) ? IDX_IFACE_CONFIG : IDX_MISC_INFO,
            8'h00), 1'b0);
      end
      // mono and eight-bit formats
      for (i = 0; i < 4; i++)
      begin
         do_frame(cw(1'b1, 1'b1, 1'b0, IDX_DATA_FORMAT, fmts[i]), 1'b0);
         repeat (2) do_frame(cw(1'b1, 1'b0, 1'b0, 4'h0, 8'($random(seed))), 1'b0);
      end
      // sticky overrange, then refresh again
      for (i = 0; i < 10; i++)
         do_frame(cw(i > 6, 1'b0, 1'b0, 4'h1, 8'($random(seed))), 1'b0);
      // layout switches with a pending read
      do_frame(cw(1'b1, 1'b0, 1'b1, 4'h2, 8'h00), 1'b1);
      for (i = 0; i < 6; i++)
         do_frame(cw(1'b1, 1'b0, 1'($random(seed)), 4'($random(seed)), 8'($random(seed))), 1'b1);
      do_frame(cw(1'b1, 1'b0, 1'b1, 4'h5, 8'h00), 1'b0);
      do_frame(cw(1'b1, 1'b0, 1'b0, 4'h0, 8'h11), 1'b0);
      do_frame(cw(1'b1, 1'b0, 1'b1, 4'h0, 8'h00), 1'b0);
      report_and_stop();
   end
endmodule : tb_codec_tdm_control_slots

// File: verilog/codec_tdm_control_slots.sv
// time-slot serial interface of a stereo codec: control, playback, status and capture
// assumes bit clock and frame sync come from the host; core side runs on clk
// Functional notes
// - six sixteen-bit slots per sample
// - shared wire: three slots in, three out
// - split wires: in and out slots concurrent
// - read request selects readback over status word
// - readback word uses control word layout
// - readback same sample or next sample slot
// - layout switches repeat or drop pending read
// - reads of addresses 11,14,15 return status
// - writes to invalid addresses change nothing
// - status refreshed at frame boundary
// - control word bit layout
// - protected registers change only with mode change
// - mode change mutes the DAC outputs
// - overrange clear refreshes, else sticky maximum
// - overrange clear acts within two samples
// - control word resets to C000
// - data words sixteen bits, MSB first
// - eight-bit modes use upper byte only
// - mono plays one sample, captures left
// - data registers reset to zero
// - status word returns read request low
`timescale 1ns/100ps
module codec_tdm_control_slots
   import codec_tdm_pkg::*;
(
   // system clock and reset
   input wire logic clk,
   input wire logic reset,
   // serial link
   input wire logic bitClk,
   input wire logic frameSync,
   input wire logic serialInPin,
   output logic serialOutPin,
   output logic serialOutPinEn,
   input wire logic slotLayoutSelect,
   // core side audio
   input wire logic [15:0] captureLeft,
   input wire logic [15:0] captureRight,
   input wire logic [1:0] overLeft,
   input wire logic [1:0] overRight,
   output logic [15:0] dacLeft,
   output logic [15:0] dacRight,
   output logic dacMute,
   output logic monoMode,
   output logic eightBitMode
);

   // invalid index addresses
   function automatic logic isInvalid(input logic [3:0] addr);
      isInvalid = (addr == IDX_INVALID_A) || (addr == IDX_INVALID_B) || (addr == IDX_INVALID_C);
   endfunction : isInvalid

   // eight-bit word: low byte forced to zero
   function automatic logic [15:0] upperOnly(input logic [15:0] w, input logic eight);
      upperOnly = eight ? {w[15:8], 8'h00} : w;
   endfunction : upperOnly

   logic linkRstMeta; // reset synchroniser, first stage
   logic linkReset; // reset in link domain
   logic layoutMeta; // layout pin, first stage
   logic layoutSync; // layout pin, synchronised
   logic layoutFrame; // layout held for the current frame
   logic active; // inside the device's slots
   logic [2:0] slotCnt; // slot of the next bit edge
   logic [3:0] bitCnt; // bit of the next bit edge
   logic edgeActive;
   logic [2:0] edgeSlot;
   logic [3:0] edgeBit;
   logic edgeLayout;
   logic [2:0] lastSlot;
   logic wordDone;
   logic [15:0] rxShift; // incoming bits
   logic [15:0] rxWord;
   ctrl_word_s rxCtrl;
   logic isOut;
   logic [1:0] outRole;
   ctrl_word_s ctrlReg; // control word register
   logic [7:0] indexRegs [16]; // indirect registers
   logic pendReq; // readback pending
   ctrl_word_s pendWord; // control word of the pending read
   logic [15:0] playLeft;
   logic [15:0] playRight;
   logic [1:0] ovrLeft; // status overrange, left
   logic [1:0] ovrRight; // status overrange, right
   logic [1:0] next_ovrLeft; // overrange level due at the next frame boundary, left
   logic [1:0] next_ovrRight; // overrange level due at the next frame boundary, right
   logic linkMono;
   logic linkEight;
   logic [15:0] statusWord;
   logic [15:0] chosen;
   logic [15:0] txShift; // outgoing bits
   logic linkToggle; // frame event toward core
   frame_xfer_s xferHold;
   logic capMeta;
   logic capSync;
   logic capSeen;
   capture_s capLink; // capture copy in link domain
   logic tgMeta;
   logic tgSync;
   logic tgSeen;
   logic capToggle; // capture event toward link
   capture_s capHold;

   // reset and layout pin into the link domain
   always_ff @(posedge bitClk)
   begin
      linkRstMeta <= reset;
      linkReset <= linkRstMeta;
      layoutMeta <= slotLayoutSelect;
      layoutSync <= layoutMeta;
   end

   // position of this bit edge; frame sync marks slot 0 bit 0
   assign edgeActive = frameSync | active;
   assign edgeSlot = frameSync ? CTRL_SLOT : slotCnt;
   assign edgeBit = frameSync ? 4'h0 : bitCnt;
   assign edgeLayout = frameSync ? layoutSync : layoutFrame;
   assign lastSlot = edgeLayout ? LAST_SLOT_SPLIT : LAST_SLOT_SHARED;
   assign wordDone = edgeActive && (edgeBit == LAST_BIT);
   assign rxWord = {rxShift[14:0], serialInPin};
   assign rxCtrl = rxWord;
   // outputs: slots 3..5 on a shared wire, 0..2 beside inputs on split wires
   assign isOut = edgeActive && (edgeLayout || (edgeSlot >= FIRST_OUT_SLOT_SHARED));
   assign outRole = edgeLayout ? edgeSlot[1:0] : 2'(edgeSlot - FIRST_OUT_SLOT_SHARED);
   assign linkMono = indexRegs[IDX_DATA_FORMAT][MONO_BIT];
   assign linkEight = |indexRegs[IDX_DATA_FORMAT][FORMAT_LSB +: 2];

   // slot and bit counters
   always_ff @(posedge bitClk)
   begin
      if (linkReset)
      begin
         active <= 1'b0;
         slotCnt <= 3'h0;
         bitCnt <= 4'h0;
         layoutFrame <= 1'b0;
      end
      else if (edgeActive)
      begin
         layoutFrame <= edgeLayout;
         bitCnt <= 4'(edgeBit + 4'h1);
         slotCnt <= wordDone ? 3'(edgeSlot + 3'h1) : edgeSlot;
         active <= !(wordDone && (edgeSlot == lastSlot));
      end
   end

   // receive shift register
   always_ff @(posedge bitClk)
   begin
      if (linkReset)
         rxShift <= DATA_RESET;
      else if (edgeActive)
         rxShift <= rxWord;
   end

   // control word: invalid address without read leaves the control register as it was
   always_ff @(posedge bitClk)
   begin
      if (linkReset)
      begin
         ctrlReg <= CTRL_RESET;
         pendReq <= 1'b0;
         pendWord <= CTRL_RESET;
      end
      else if (wordDone && (edgeSlot == CTRL_SLOT))
      begin
         if (!(isInvalid(rxCtrl.indexAddress) && !rxCtrl.readbackRequest))
            ctrlReg <= rxCtrl;
         // pending read; a later control word overwrites one never sent
         pendReq <= rxCtrl.readbackRequest && !isInvalid(rxCtrl.indexAddress);
         pendWord <= rxCtrl;
      end
   end

   // indirect register writes, protected ones need mode change enable
   always_ff @(posedge bitClk)
   begin
      if (linkReset)
      begin
         for (int i = 0; i < 16; i++)
            indexRegs[i] <= INDEX_RESET;
      end
      else if (wordDone && (edgeSlot == CTRL_SLOT) && !rxCtrl.readbackRequest
               && !isInvalid(rxCtrl.indexAddress))
      begin
         if ((rxCtrl.indexAddress == IDX_DATA_FORMAT) || (rxCtrl.indexAddress == IDX_MISC_INFO))
         begin
            if (rxCtrl.modeChangeEnable)
               indexRegs[rxCtrl.indexAddress] <= rxCtrl.indexData;
         end
         else if (rxCtrl.indexAddress == IDX_IFACE_CONFIG)
         begin
            indexRegs[IDX_IFACE_CONFIG] <= rxCtrl.indexData;
            // calibration bit keeps its value unless mode change is on
            if (!rxCtrl.modeChangeEnable)
               indexRegs[IDX_IFACE_CONFIG][AUTO_CALIBRATION_BIT_BIT] <= indexRegs[IDX_IFACE_CONFIG][AUTO_CALIBRATION_BIT_BIT];
         end
         else
            indexRegs[rxCtrl.indexAddress] <= rxCtrl.indexData;
      end
   end

   // playback words, eight-bit and mono handling
   always_ff @(posedge bitClk)
   begin
      if (linkReset)
      begin
         playLeft <= DATA_RESET;
         playRight <= DATA_RESET;
      end
      else if (wordDone && (edgeSlot == LEFT_SLOT))
         playLeft <= upperOnly(rxWord, linkEight);
      else if (wordDone && (edgeSlot == RIGHT_SLOT))
         playRight <= linkMono ? playLeft : upperOnly(rxWord, linkEight);
   end

   // fresh level while clearing, else sticky: keep the largest level seen
   assign next_ovrLeft = (ctrlReg.overrangeClear || (capLink.overLeft > ovrLeft))
                         ? capLink.overLeft : ovrLeft;
   assign next_ovrRight = (ctrlReg.overrangeClear || (capLink.overRight > ovrRight))
                          ? capLink.overRight : ovrRight;

   // overrange status refreshed at each frame boundary
   always_ff @(posedge bitClk)
   begin
      if (linkReset)
      begin
         ovrLeft <= 2'h0;
         ovrRight <= 2'h0;
      end
      else if (frameSync)
      begin
         ovrLeft <= next_ovrLeft;
         ovrRight <= next_ovrRight;
      end
   end

   // status word: read request low, reserved bits zero; a status slot that starts on the
   // frame sync edge must already carry the refreshed levels, not last frame's
   assign statusWord = {2'b00, 1'b0, 1'b0, REVISION_ID, 4'h0,
                        frameSync ? next_ovrRight : ovrRight,
                        frameSync ? next_ovrLeft : ovrLeft};

   // word for the output slot starting now
   always_comb
   begin
      chosen = statusWord;
      case (outRole)
         2'h0:
            if (pendReq)
               chosen = {pendWord.overrangeClear, pendWord.modeChangeEnable, 1'b1, 1'b0,
                         pendWord.indexAddress, indexRegs[pendWord.indexAddress]};
         2'h1:
            chosen = upperOnly(capLink.left, linkEight);
         2'h2:
            chosen = upperOnly(linkMono ? capLink.left : capLink.right, linkEight);
         default:
            chosen = statusWord;
      endcase
   end

   // transmit shifter, MSB first, one bit per edge
   always_ff @(posedge bitClk)
   begin
      if (linkReset)
      begin
         serialOutPin <= 1'b0;
         serialOutPinEn <= 1'b0;
         txShift <= DATA_RESET;
      end
      else
      begin
         serialOutPinEn <= isOut;
         if (isOut && (edgeBit == 4'h0))
         begin
            serialOutPin <= chosen[15];
            txShift <= {chosen[14:0], 1'b0};
         end
         else
         begin
            serialOutPin <= txShift[15];
            txShift <= {txShift[14:0], 1'b0};
         end
      end
   end

   // frame event toward the core with stable results
   always_ff @(posedge bitClk)
   begin
      if (linkReset)
      begin
         linkToggle <= 1'b0;
         xferHold <= {DATA_RESET, DATA_RESET, 1'b1, 1'b0, 1'b0};
      end
      else if (frameSync)
      begin
         linkToggle <= !linkToggle;
         xferHold <= {playLeft, playRight, ctrlReg.modeChangeEnable, linkMono, linkEight};
      end
   end

   // capture words taken once the core's toggle has settled
   always_ff @(posedge bitClk)
   begin
      if (linkReset)
      begin
         capMeta <= 1'b0;
         capSync <= 1'b0;
         capSeen <= 1'b0;
         capLink <= '0;
      end
      else
      begin
         capMeta <= capToggle;
         capSync <= capMeta;
         capSeen <= capSync;
         if (capSync != capSeen)
            capLink <= capHold;
      end
   end

   // core side: take frame results, hand back fresh capture words
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tgMeta <= 1'b0;
         tgSync <= 1'b0;
         tgSeen <= 1'b0;
         capToggle <= 1'b0;
         capHold <= '0;
         dacLeft <= DATA_RESET;
         dacRight <= DATA_RESET;
         dacMute <= 1'b1;
         monoMode <= 1'b0;
         eightBitMode <= 1'b0;
      end
      else
      begin
         tgMeta <= linkToggle;
         tgSync <= tgMeta;
         tgSeen <= tgSync;
         if (tgSync != tgSeen)
         begin
            {dacLeft, dacRight, dacMute, monoMode, eightBitMode} <= xferHold;
            capHold <= {captureLeft, captureRight, overLeft, overRight};
            capToggle <= !capToggle;
         end
      end
   end

   // read request on a shared wire, control slot just received
   sequence s_sharedRead;
      wordDone && (edgeSlot == CTRL_SLOT) && !edgeLayout && rxCtrl.readbackRequest
         && !isInvalid(rxCtrl.indexAddress);
   endsequence

   sequence s_sharedStatus;
      wordDone && (edgeSlot == CTRL_SLOT) && !edgeLayout && !rxCtrl.readbackRequest;
   endsequence

   property p_readback_slot3;
      @(posedge bitClk) disable iff (linkReset)
      s_sharedRead |-> ##36 serialOutPin;
   endproperty
   a_readback_slot3: assert property (p_readback_slot3) else $error("readback flag missing in slot 3");

   property p_status_readback_request_low;
      @(posedge bitClk) disable iff (linkReset)
      s_sharedStatus |-> ##36 !serialOutPin;
   endproperty
   a_status_readback_request_low: assert property (p_status_readback_request_low) else $error("status word read request not low");

   property p_shared_out_start;
      @(posedge bitClk) disable iff (linkReset)
      $rose(serialOutPinEn) && !layoutFrame |-> $past(edgeSlot) == FIRST_OUT_SLOT_SHARED;
   endproperty
   a_shared_out_start: assert property (p_shared_out_start) else $error("shared wire driven before slot 3");

   property p_split_concurrent;
      @(posedge bitClk) disable iff (linkReset)
      frameSync && layoutSync |=> serialOutPinEn [*8];
   endproperty
   a_split_concurrent: assert property (p_split_concurrent) else $error("split output not beside control");

   property p_invalid_write;
      @(posedge bitClk) disable iff (linkReset)
      wordDone && (edgeSlot == CTRL_SLOT) && isInvalid(rxCtrl.indexAddress) && !rxCtrl.readbackRequest
         |=> ctrlReg == $past(ctrlReg);
   endproperty
   a_invalid_write: assert property (p_invalid_write) else $error("invalid write changed control");

   property p_protected_format;
      @(posedge bitClk) disable iff (linkReset)
      wordDone && (edgeSlot == CTRL_SLOT) && (rxCtrl.indexAddress == IDX_DATA_FORMAT)
         && !rxCtrl.modeChangeEnable |=> $stable(indexRegs[IDX_DATA_FORMAT]);
   endproperty
   a_protected_format: assert property (p_protected_format) else $error("format changed without mode change");

   property p_eight_bit_low;
      @(posedge bitClk) disable iff (linkReset)
      wordDone && (edgeSlot == LEFT_SLOT) && linkEight |=> playLeft[7:0] == 8'h00;
   endproperty
   a_eight_bit_low: assert property (p_eight_bit_low) else $error("low byte kept in eight-bit mode");

   property p_mono_play;
      @(posedge bitClk) disable iff (linkReset)
      wordDone && (edgeSlot == RIGHT_SLOT) && linkMono |=> playRight == playLeft;
   endproperty
   a_mono_play: assert property (p_mono_play) else $error("mono right differs from left");

   property p_sticky_over;
      @(posedge bitClk) disable iff (linkReset)
      frameSync && !ctrlReg.overrangeClear |=> ovrLeft >= $past(ovrLeft) && ovrRight >= $past(ovrRight);
   endproperty
   a_sticky_over: assert property (p_sticky_over) else $error("overrange dropped while sticky");

   property p_reset_state;
      @(posedge clk) disable iff (1'b0)
      reset |=> dacMute && (dacLeft == DATA_RESET) && (dacRight == DATA_RESET);
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("core outputs wrong after reset");

endmodule : codec_tdm_control_slots

// File: verilog/codec_tdm_pkg.sv
// constants, field layouts and carriers for the codec time-slot interface
// assumes a host serial port in multichannel mode drives bit clock and frame sync
package codec_tdm_pkg;

   // slot geometry
   localparam int SLOT_BITS = 16;
   localparam logic [2:0] LAST_SLOT_SHARED = 3'h5;
   localparam logic [2:0] LAST_SLOT_SPLIT = 3'h2;
   localparam logic [2:0] FIRST_OUT_SLOT_SHARED = 3'h3;
   localparam logic [2:0] CTRL_SLOT = 3'h0;
   localparam logic [2:0] LEFT_SLOT = 3'h1;
   localparam logic [2:0] RIGHT_SLOT = 3'h2;
   localparam logic [3:0] LAST_BIT = 4'hF;

   // reset values
   localparam logic [15:0] CTRL_RESET = 16'hC000;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [7:0] INDEX_RESET = 8'h00;

   // index addresses with special handling
   localparam logic [3:0] IDX_DATA_FORMAT = 4'h8;
   localparam logic [3:0] IDX_IFACE_CONFIG = 4'h9;
   localparam logic [3:0] IDX_MISC_INFO = 4'hC;
   localparam logic [3:0] IDX_INVALID_A = 4'hB;
   localparam logic [3:0] IDX_INVALID_B = 4'hE;
   localparam logic [3:0] IDX_INVALID_C = 4'hF;

   // field positions inside index registers
   localparam int AUTO_CALIBRATION_BIT_BIT = 3;
   localparam int MONO_BIT = 4;
   localparam int FORMAT_LSB = 5;

   // revision field of the status word, value arbitrary
   localparam logic [3:0] REVISION_ID = 4'hA;

   // control word and index readback layout
   typedef struct packed
   {
      logic overrangeClear;
      logic modeChangeEnable;
      logic readbackRequest;
      logic reserved;
      logic [3:0] indexAddress;
      logic [7:0] indexData;
   } ctrl_word_s;

   // frame results handed from link to core
   typedef struct packed
   {
      logic [15:0] left;
      logic [15:0] right;
      logic mute;
      logic mono;
      logic eightBit;
   } frame_xfer_s;

   // capture words and overrange levels handed from core to link
   typedef struct packed
   {
      logic [15:0] left;
      logic [15:0] right;
      logic [1:0] overLeft;
      logic [1:0] overRight;
   } capture_s;

endpackage : codec_tdm_pkg
